// ==== bench/cea_monitor_test.sv ====
`timescale 1ns/1ps
module cea_monitor_test;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   cea_pkg::cea_apb_req_t apbReq = '0;
   cea_pkg::cea_path_t pathIn = '0;
   cea_pkg::cea_ovf_t pathOvf = '0;
   logic [8:0] amp = 9'h000;
   logic [9:0] extVal = 10'h200;
   logic trigReq = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic signed [9:0] adcSample;
   logic signed [9:0] emuInSample;
   logic [7:0] gain;
   logic [9:0] extSample;
   logic trigPin;
   logic [11:0] dacSample;
   logic firstOvf;
   logic lastOvf;
   logic extOvf;
   int failCount = 0;
   int numChecks = 0;

   always #2 clk = ~clk;

   cea_partner partner (.clk(clk), .resetn(resetn), .amp(amp), .extVal(extVal), .trigReq(trigReq),
      .adcSample(adcSample), .extSample(extSample), .trigPin(trigPin));

   cea_monitor dut (.clk(clk), .resetn(resetn), .apbReq(apbReq), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .adcSample(adcSample), .emuInSample(emuInSample), .rx_gain_control_out(gain),
      .pathIn(pathIn), .pathOvf(pathOvf), .left_digital_input_connector(extSample), .triggerIn(trigPin),
      .dacSample(dacSample), .first_paths_overflow_flag(firstOvf), .last_paths_overflow_flag(lastOvf),
      .external_add_overflow_flag(extOvf));

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         failCount++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
      output logic err);
      @(posedge clk);
      apbReq <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic e;
      apb(1'b1, a, d, rd, e);
      chk("write response", {31'h0, e}, 32'h0);
   endtask : wr

   task automatic test_regs();
      logic [31:0] rd;
      logic e;
      chk("gain at reset", {24'h0, gain}, 32'h80);
      chk("dac at reset", {20'h0, dacSample}, 32'h0);
      apb(1'b0, cea_pkg::ADDR_TARGET, 32'h0, rd, e);
      chk("target reset", rd, 32'h40);
      apb(1'b0, cea_pkg::ADDR_GAINCFG, 32'h0, rd, e);
      chk("rate reset", rd & 32'h1f, 32'h0);
      apb(1'b0, 8'h20, 32'h0, rd, e);
      chk("unmapped read", {rd[30:0], e}, 32'h1);
      apb(1'b1, cea_pkg::ADDR_FLAGS, 32'h7, rd, e);
      chk("read-only write", {31'h0, e}, 32'h1);
      $display("test regs done");
   endtask : test_regs

   task automatic test_fixed();
      logic [31:0] rd;
      logic e;
      wr(cea_pkg::ADDR_FIXGAIN, 32'h5a);
      wr(cea_pkg::ADDR_GAINCFG, 32'h00);
      repeat (4) @(posedge clk);
      chk("fixed gain", {24'h0, gain}, 32'h5a);
      apb(1'b0, cea_pkg::ADDR_FIXGAIN, 32'h0, rd, e);
      chk("fixed readback", rd, 32'h5a);
      $display("test fixed done");
   endtask : test_fixed

   task automatic test_auto();
      logic [7:0] g1;
      logic [7:0] g2;
      logic [31:0] rd;
      logic e;
      logic signed [9:0] a;
      amp <= 9'h010;
      wr(cea_pkg::ADDR_GAINCFG, 32'h80);
      @(posedge clk);
      a = adcSample;
      @(posedge clk);
      chk("input path", {22'h0, emuInSample}, {22'h0, a});
      repeat (600) @(posedge clk);
      g1 = gain;
      chk("gain rises", {31'h0, g1 > 8'h80}, 32'h1);
      amp <= 9'h1f4;
      repeat (600) @(posedge clk);
      g2 = gain;
      chk("gain falls", {31'h0, g2 < g1}, 32'h1);
      chk("gain floor", {24'h0, g2}, 32'h0);
      // A small input now pulls the gain up, so only the slow rate keeps it still.
      wr(cea_pkg::ADDR_GAINCFG, 32'h94);
      amp <= 9'h010;
      repeat (300) @(posedge clk);
      g1 = gain;
      repeat (2000) @(posedge clk);
      chk("slow rate hold", {24'h0, gain}, {24'h0, g1});
      apb(1'b0, cea_pkg::ADDR_CAPSTAT, 32'h0, rd, e);
      chk("gain status", {24'h0, rd[7:0]}, {24'h0, g1});
      $display("test auto done");
   endtask : test_auto

   task automatic dac_case(input logic [11:0] o, input logic [9:0] x, input logic [11:0] d, input logic f);
      pathIn.outSample <= o;
      extVal <= x;
      repeat (8) @(posedge clk);
      chk("dac sample", {20'h0, dacSample}, {20'h0, d});
      chk("ext overflow", {31'h0, extOvf}, {31'h0, f});
   endtask : dac_case

   task automatic test_ext();
      wr(cea_pkg::ADDR_EXTCFG, 32'h1);
      dac_case(12'h100, 10'h280, 12'h180, 1'b0);
      dac_case(12'h7f0, 10'h3ff, 12'h7ff, 1'b1);
      dac_case(12'h810, 10'h000, 12'h800, 1'b1);
      wr(cea_pkg::ADDR_EXTCFG, 32'h0);
      dac_case(12'h100, 10'h280, 12'h100, 1'b0);
      pathOvf <= '{firstOvf: 1'b1, lastOvf: 1'b0, extOvf: 1'b0};
      repeat (3) @(posedge clk);
      chk("first flags", {30'h0, firstOvf, lastOvf}, 32'h2);
      pathOvf <= '{firstOvf: 1'b0, lastOvf: 1'b1, extOvf: 1'b0};
      repeat (3) @(posedge clk);
      chk("last flags", {30'h0, firstOvf, lastOvf}, 32'h1);
      pathOvf <= '0;
      $display("test ext done");
   endtask : test_ext

   // Each status poll spans four clocks, so span is the busy time in polls.
   task automatic cap_finish(input logic [7:0] exp, input int span);
      logic [31:0] s;
      logic e;
      bit busySeen;
      int n;
      int polls;
      busySeen = 0;
      polls = 0;
      for (n = 0; n < 1500; n++) begin
         apb(1'b0, cea_pkg::ADDR_CAPSTAT, 32'h0, s, e);
         if (s[9] === 1'b1) begin
            busySeen = 1;
            polls++;
         end
         if (busySeen && s[9] === 1'b0 && s[8] === 1'b1) break;
      end
      chk("capture done", {30'h0, busySeen, s[8]}, 32'h3);
      chk("capture span", {31'h0, polls >= span - 2 && polls <= span + 2}, 32'h1);
      for (n = 0; n < cea_pkg::CAP_DEPTH; n++) begin
         apb(1'b0, cea_pkg::ADDR_CAPDATA, 32'h0, s, e);
         chk("capture byte", {24'h0, s[7:0]}, {24'h0, exp});
      end
   endtask : cap_finish

   task automatic test_capture();
      logic [31:0] s;
      logic e;
      pathIn.partialSum <= 18'h12345;
      wr(cea_pkg::ADDR_CAPCFG, 32'h0343);
      repeat (200) @(posedge clk);
      apb(1'b0, cea_pkg::ADDR_CAPSTAT, 32'h0, s, e);
      chk("waits for trigger", {30'h0, s[9], s[8]}, 32'h0);
      trigReq <= 1'b1;
      repeat (5) @(posedge clk);
      trigReq <= 1'b0;
      cap_finish(8'h48, 512);
      pathIn.outSample <= 12'h5a3;
      wr(cea_pkg::ADDR_CAPCFG, 32'h0025);
      cap_finish(8'h5a, 128);
      extVal <= 10'h2c4;
      repeat (8) @(posedge clk);
      wr(cea_pkg::ADDR_CAPCFG, 32'h0015);
      cap_finish(8'hb1, 128);
      wr(cea_pkg::ADDR_GAINCFG, 32'h00);
      wr(cea_pkg::ADDR_CAPCFG, 32'h0035);
      cap_finish(8'h5a, 128);
      amp <= 9'h000;
      repeat (2) @(posedge clk);
      wr(cea_pkg::ADDR_CAPCFG, 32'h0005);
      cap_finish(8'h00, 128);
      $display("test capture done");
   endtask : test_capture

   task automatic testDone();
      $display("checks %0d mismatches %0d", numChecks, failCount);
      if (failCount == 0 && numChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : testDone

   // The whole sequence needs about 20000 cycles.
   initial begin
      #(4 * 40000);
      failCount++;
      testDone();
   end

   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      test_regs();
      test_fixed();
      test_auto();
      test_ext();
      test_capture();
      testDone();
   end
endmodule : cea_monitor_test

// ==== bench/cea_partner.sv ====
`timescale 1ns/1ps
// Stands in for the front-end amplifier, the waveform source and the trigger line.
// The input swings between +amp and -amp, so its magnitude is amp on every sample.
module cea_partner (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Commands from the bench.
   input wire logic [8:0] amp,
   input wire logic [9:0] extVal,
   input wire logic trigReq,
   // Pins toward the device.
   output logic signed [9:0] adcSample,
   output logic [9:0] extSample,
   output logic trigPin
);
   logic sign_ff;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sign_ff <= 1'b0;
         adcSample <= 10'sh000;
         extSample <= 10'h200;
         trigPin <= 1'b0;
      end else begin
         sign_ff <= ~sign_ff;
         adcSample <= sign_ff ? -$signed({1'b0, amp}) : $signed({1'b0, amp});
         extSample <= extVal;
         trigPin <= trigReq;
      end
   end
endmodule : cea_partner

// ==== verilog/cea_monitor.sv ====
`timescale 1ns/1ps
module cea_monitor #(
   parameter int unsigned DEPTH = cea_pkg::CAP_DEPTH
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // APB slave.
   input wire cea_pkg::cea_apb_req_t apbReq,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Input path and gain DAC.
   input wire logic signed [9:0] adcSample,
   output logic signed [9:0] emuInSample,
   output logic [7:0] rx_gain_control_out,
   // Multipath results from the core.
   input wire cea_pkg::cea_path_t pathIn,
   input wire cea_pkg::cea_ovf_t pathOvf,
   // External additive stream and trigger.
   input wire logic [9:0] left_digital_input_connector,
   input wire logic triggerIn,
   // DAC sample and test points.
   output logic [11:0] dacSample,
   output logic first_paths_overflow_flag,
   output logic last_paths_overflow_flag,
   output logic external_add_overflow_flag
);

   localparam int AW = $clog2(DEPTH);

   // Register file.
   logic [7:0] gainCfg_ff, nxt_gainCfg;
   logic [7:0] fixGain_ff, nxt_fixGain;
   logic extEn_ff, nxt_extEn;
   logic [7:0] target_ff, nxt_target;
   logic [15:0] capCfg_ff, nxt_capCfg;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready;
   logic pslverr_ff, nxt_pslverr;

   // Pin synchronisers for the external stream and the trigger.
   logic [9:0] ext1_ff, ext2_ff, ext3_ff, extLvl_ff;
   logic [2:0] trig_ff;
   logic [9:0] extSample;
   logic trigEdge, trigLvl_ff;

   // Gain loop.
   logic [9:0] magnitude;
   logic [16:0] magSum_ff, nxt_magSum;
   logic [6:0] avgCnt_ff, nxt_avgCnt;
   logic [9:0] avgMag_ff, nxt_avgMag;
   logic [19:0] rateCnt_ff, nxt_rateCnt;
   logic [7:0] loopGain_ff, nxt_loopGain;
   logic [7:0] gainOut_ff, nxt_gainOut;
   logic signed [9:0] emuIn_ff, nxt_emuIn;
   logic [19:0] rateMask;

   // Output sum and overflow flags.
   logic signed [12:0] extSum;
   logic [11:0] dac_ff, nxt_dac;
   logic ovfA_ff, ovfB_ff, ovfC_ff, nxt_ovfC;

   // Capture.
   logic [7:0] capMem_ff [DEPTH];
   logic [AW-1:0] wrPtr_ff, nxt_wrPtr;
   logic [AW-1:0] rdPtr_ff, nxt_rdPtr;
   logic capBusy_ff, nxt_capBusy;
   logic capDone_ff, nxt_capDone;
   logic [7:0] decCnt_ff, nxt_decCnt;
   logic [7:0] capByte;
   logic capTick, capWrite;

   logic apbAccess, apbWrite, apbRead;
   assign apbAccess = apbReq.psel & apbReq.penable & ~pready_ff;
   assign apbWrite = apbAccess & apbReq.pwrite;
   assign apbRead = apbAccess & ~apbReq.pwrite;

   // A change is taken once the second and third stages agree.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ext1_ff <= 10'h000;
         ext2_ff <= 10'h000;
         ext3_ff <= 10'h000;
         extLvl_ff <= 10'h000;
         trig_ff <= 3'h0;
         trigLvl_ff <= 1'b0;
      end else begin
         ext1_ff <= left_digital_input_connector;
         ext2_ff <= ext1_ff;
         ext3_ff <= ext2_ff;
         if (ext2_ff == ext3_ff) begin
            extLvl_ff <= ext3_ff;
         end
         trig_ff <= {trig_ff[1:0], triggerIn};
         if (trig_ff[1] == trig_ff[2]) begin
            trigLvl_ff <= trig_ff[2];
         end
      end
   end
   assign extSample = extLvl_ff;
   assign trigEdge = (trig_ff[1] == trig_ff[2]) & trig_ff[2] & ~trigLvl_ff;

   always_comb begin
      nxt_gainCfg = gainCfg_ff;
      nxt_fixGain = fixGain_ff;
      nxt_extEn = extEn_ff;
      nxt_target = target_ff;
      nxt_capCfg = capCfg_ff;
      nxt_prdata = 32'h0000_0000;
      nxt_pready = apbAccess;
      nxt_pslverr = 1'b0;
      if (apbWrite) begin
         case (apbReq.paddr)
            cea_pkg::ADDR_GAINCFG: nxt_gainCfg = apbReq.pwdata[7:0];
            cea_pkg::ADDR_FIXGAIN: nxt_fixGain = apbReq.pwdata[7:0];
            cea_pkg::ADDR_EXTCFG: nxt_extEn = apbReq.pwdata[0];
            cea_pkg::ADDR_TARGET: nxt_target = apbReq.pwdata[7:0];
            cea_pkg::ADDR_CAPCFG: nxt_capCfg = apbReq.pwdata[15:0];
            default: nxt_pslverr = 1'b1;
         endcase
      end
      if (capBusy_ff) begin
         nxt_capCfg[cea_pkg::CAP_ARM_BIT] = 1'b0;
      end
      if (apbRead) begin
         case (apbReq.paddr)
            cea_pkg::ADDR_GAINCFG: nxt_prdata = {24'h000000, gainCfg_ff};
            cea_pkg::ADDR_FIXGAIN: nxt_prdata = {24'h000000, fixGain_ff};
            cea_pkg::ADDR_EXTCFG: nxt_prdata = {31'h0000_0000, extEn_ff};
            cea_pkg::ADDR_TARGET: nxt_prdata = {24'h000000, target_ff};
            cea_pkg::ADDR_CAPCFG: nxt_prdata = {16'h0000, capCfg_ff};
            cea_pkg::ADDR_CAPSTAT: nxt_prdata = {16'h0000, 6'h00, capBusy_ff, capDone_ff, gainOut_ff};
            cea_pkg::ADDR_CAPDATA: nxt_prdata = {24'h000000, capMem_ff[rdPtr_ff]};
            cea_pkg::ADDR_FLAGS: nxt_prdata = {29'h0000_0000, ovfC_ff, ovfB_ff, ovfA_ff};
            default: nxt_pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gainCfg_ff <= {3'h0, cea_pkg::RATE_RESET};
         fixGain_ff <= cea_pkg::GAIN_RESET;
         extEn_ff <= 1'b0;
         target_ff <= cea_pkg::TARGET_RESET;
         capCfg_ff <= {cea_pkg::DEC_RESET, 8'h00};
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         gainCfg_ff <= nxt_gainCfg;
         fixGain_ff <= nxt_fixGain;
         extEn_ff <= nxt_extEn;
         target_ff <= nxt_target;
         capCfg_ff <= nxt_capCfg;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // Gain loop: magnitude of a real sample is its absolute value.
   assign magnitude = adcSample[9] ? 10'(-adcSample) : adcSample;
   // Settings above the maximum are clamped so the update never stalls.
   assign rateMask = (gainCfg_ff[4:0] > 5'(cea_pkg::RATE_MAX)) ? 20'hfffff :
                     20'((21'h000001 << gainCfg_ff[4:0]) - 21'h000001);

   always_comb begin
      nxt_avgCnt = 7'(avgCnt_ff + 7'h01);
      nxt_magSum = 17'(magSum_ff + {7'h00, magnitude});
      nxt_avgMag = avgMag_ff;
      if (avgCnt_ff == 7'h7f) begin
         nxt_avgMag = 10'(nxt_magSum >> cea_pkg::AVG_LOG2);
         nxt_magSum = 17'h00000;
      end
      nxt_rateCnt = 20'(rateCnt_ff + 20'h00001);
      nxt_loopGain = loopGain_ff;
      if ((rateCnt_ff & rateMask) == rateMask) begin
         nxt_rateCnt = 20'h00000;
         // Compare the 10-bit magnitude, scaled down to 8 bits, against target.
         if ({avgMag_ff[9:2]} > target_ff && loopGain_ff != 8'h00) begin
            nxt_loopGain = 8'(loopGain_ff - 8'h01);
         end else if (avgMag_ff[9:2] < target_ff && loopGain_ff != 8'hff) begin
            nxt_loopGain = 8'(loopGain_ff + 8'h01);
         end
      end
      nxt_gainOut = gainCfg_ff[cea_pkg::GAIN_EN_BIT] ? loopGain_ff : fixGain_ff;
      nxt_emuIn = adcSample;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         avgCnt_ff <= 7'h00;
         magSum_ff <= 17'h00000;
         avgMag_ff <= 10'h000;
         rateCnt_ff <= 20'h00000;
         loopGain_ff <= cea_pkg::GAIN_RESET;
         gainOut_ff <= cea_pkg::GAIN_RESET;
         emuIn_ff <= 10'sh000;
      end else begin
         avgCnt_ff <= nxt_avgCnt;
         magSum_ff <= nxt_magSum;
         avgMag_ff <= nxt_avgMag;
         rateCnt_ff <= nxt_rateCnt;
         loopGain_ff <= nxt_loopGain;
         gainOut_ff <= nxt_gainOut;
         emuIn_ff <= nxt_emuIn;
      end
   end

   // External addition: the unsigned stream is recentred, then added with saturation.
   assign extSum = 13'(signed'(pathIn.outSample)) +
                   (extEn_ff ? 13'(signed'({~extSample[9], extSample[8:0]})) : 13'sh0000);
   always_comb begin
      nxt_ovfC = (extSum[12] != extSum[11]);
      nxt_dac = extSum[11:0];
      if (nxt_ovfC) begin
         nxt_dac = extSum[12] ? 12'h800 : 12'h7ff;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dac_ff <= 12'h000;
         ovfA_ff <= 1'b0;
         ovfB_ff <= 1'b0;
         ovfC_ff <= 1'b0;
      end else begin
         dac_ff <= nxt_dac;
         ovfA_ff <= pathOvf.firstOvf;
         ovfB_ff <= pathOvf.lastOvf;
         ovfC_ff <= nxt_ovfC;
      end
   end

   // Capture: one buffer of DEPTH bytes, filled from the selected source.
   always_comb begin
      case (cea_pkg::cea_src_t'(capCfg_ff[cea_pkg::CAP_SRC_LSB +: 3]))
         cea_pkg::SRC_INPUT: capByte = adcSample[9:2];
         cea_pkg::SRC_EXT: capByte = extSample[9:2];
         cea_pkg::SRC_OUTPUT: capByte = dac_ff[11:4];
         cea_pkg::SRC_GAIN: capByte = gainOut_ff;
         cea_pkg::SRC_PARTIAL: capByte = pathIn.partialSum[17:10];
         default: capByte = 8'h00;
      endcase
   end

   // Without fclk a sample is taken every CAPCFG decimation value + 1 clocks; with fclk, on every clock.
   assign capTick = capCfg_ff[cea_pkg::CAP_FCLK_BIT] ? 1'b1 :
                    (decCnt_ff == capCfg_ff[cea_pkg::CAP_DEC_LSB +: 8]);
   assign capWrite = capBusy_ff & capTick;

   always_comb begin
      nxt_capBusy = capBusy_ff;
      nxt_capDone = capDone_ff;
      nxt_wrPtr = wrPtr_ff;
      nxt_rdPtr = rdPtr_ff;
      nxt_decCnt = capTick ? 8'h00 : 8'(decCnt_ff + 8'h01);
      if (!capBusy_ff && capCfg_ff[cea_pkg::CAP_ARM_BIT] &&
          (!capCfg_ff[cea_pkg::CAP_TRIG_BIT] || trigEdge)) begin
         nxt_capBusy = 1'b1;
         nxt_capDone = 1'b0;
         nxt_wrPtr = '0;
         nxt_decCnt = 8'h00;
      end else if (capWrite) begin
         nxt_wrPtr = AW'(wrPtr_ff + 1'b1);
         if (wrPtr_ff == AW'(DEPTH - 1)) begin
            nxt_capBusy = 1'b0;
            nxt_capDone = 1'b1;
         end
      end
      if (apbRead && apbReq.paddr == cea_pkg::ADDR_CAPDATA) begin
         nxt_rdPtr = AW'(rdPtr_ff + 1'b1);
      end
      if (apbWrite && apbReq.paddr == cea_pkg::ADDR_CAPCFG) begin
         nxt_rdPtr = '0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         capBusy_ff <= 1'b0;
         capDone_ff <= 1'b0;
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         decCnt_ff <= 8'h00;
      end else begin
         capBusy_ff <= nxt_capBusy;
         capDone_ff <= nxt_capDone;
         wrPtr_ff <= nxt_wrPtr;
         rdPtr_ff <= nxt_rdPtr;
         decCnt_ff <= nxt_decCnt;
      end
   end

   // Storage has no reset; CAPDATA reads it at any time, so it is only valid after a completed capture.
   always_ff @(posedge clk) begin
      if (capWrite) begin
         capMem_ff[wrPtr_ff] <= capByte;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign emuInSample = emuIn_ff;
   assign rx_gain_control_out = gainOut_ff;
   assign dacSample = dac_ff;
   assign first_paths_overflow_flag = ovfA_ff;
   assign last_paths_overflow_flag = ovfB_ff;
   assign external_add_overflow_flag = ovfC_ff;

   a_fixed_gain: assert property (@(posedge clk) disable iff (!resetn)
      !gainCfg_ff[7] && $stable(fixGain_ff) |=> rx_gain_control_out == $past(fixGain_ff))
      else $error("fixed gain not driven");
   a_ovf_first: assert property (@(posedge clk) disable iff (!resetn)
      pathOvf.firstOvf |=> first_paths_overflow_flag)
      else $error("first overflow missed");
   a_ovf_last: assert property (@(posedge clk) disable iff (!resetn)
      pathOvf.lastOvf |=> last_paths_overflow_flag)
      else $error("last overflow missed");
   a_ext_ovf: assert property (@(posedge clk) disable iff (!resetn)
      external_add_overflow_flag |-> (dacSample == 12'h7ff || dacSample == 12'h800))
      else $error("overflow without saturation");
   a_ext_off: assert property (@(posedge clk) disable iff (!resetn)
      !extEn_ff |=> dacSample == $past(pathIn.outSample))
      else $error("external add not gated");
   a_gain_step: assert property (@(posedge clk) disable iff (!resetn)
      loopGain_ff != $past(loopGain_ff) |-> $past((rateCnt_ff & rateMask) == rateMask))
      else $error("gain updated off rate");
   a_cap_len: assert property (@(posedge clk) disable iff (!resetn)
      $rose(capDone_ff) |-> $past(wrPtr_ff) == AW'(DEPTH - 1))
      else $error("capture length wrong");
   a_in_pass: assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> emuInSample == $past(adcSample))
      else $error("input path broken");
   c_trig_cap: cover property (@(posedge clk) disable iff (!resetn) trigEdge && capCfg_ff[1]);
   c_cap_done: cover property (@(posedge clk) disable iff (!resetn) $rose(capDone_ff));
   c_ext_ovf: cover property (@(posedge clk) disable iff (!resetn) external_add_overflow_flag);

endmodule : cea_monitor

// ==== verilog/cea_pkg.sv ====
package cea_pkg;

   localparam int unsigned CAP_DEPTH = 512;
   localparam int unsigned AVG_LOG2 = 7;
   localparam int unsigned RATE_MAX = 20;
   localparam logic [7:0] GAIN_RESET = 8'h80;
   localparam logic [9:0] EXT_MID = 10'h200;

   // APB register byte addresses.
   localparam logic [7:0] ADDR_GAINCFG = 8'h00;
   localparam logic [7:0] ADDR_FIXGAIN = 8'h04;
   localparam logic [7:0] ADDR_EXTCFG = 8'h08;
   localparam logic [7:0] ADDR_TARGET = 8'h0c;
   localparam logic [7:0] ADDR_CAPCFG = 8'h10;
   localparam logic [7:0] ADDR_CAPSTAT = 8'h14;
   localparam logic [7:0] ADDR_CAPDATA = 8'h18;
   localparam logic [7:0] ADDR_FLAGS = 8'h1c;

   // Field positions.
   localparam int unsigned GAIN_EN_BIT = 7;
   localparam int unsigned CAP_ARM_BIT = 0;
   localparam int unsigned CAP_TRIG_BIT = 1;
   localparam int unsigned CAP_FCLK_BIT = 2;
   localparam int unsigned CAP_SRC_LSB = 4;
   localparam int unsigned CAP_DEC_LSB = 8;

   // Reset values.
   localparam logic [4:0] RATE_RESET = 5'h00;
   localparam logic [7:0] TARGET_RESET = 8'h40;
   localparam logic [7:0] DEC_RESET = 8'h00;

   typedef enum logic [2:0] {
      SRC_INPUT,
      SRC_EXT,
      SRC_OUTPUT,
      SRC_GAIN,
      SRC_PARTIAL
   } cea_src_t;

   typedef struct packed {
      logic [11:0] outSample;
      logic [17:0] partialSum;
      logic [17:0] lastSum;
   } cea_path_t;

   typedef struct packed {
      logic firstOvf;
      logic lastOvf;
      logic extOvf;
   } cea_ovf_t;

   typedef struct packed {
      logic [7:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } cea_apb_req_t;

endpackage : cea_pkg
